//--- core/snm_consts.svh
/*
  timing counts and fixed figures of the serial nor flash master link.
  assumes a 25 mhz core clock; included by bare name.
*/
`ifndef SNM_CONSTS_SVH
`define SNM_CONSTS_SVH

`define SNM_CLK_NS       40
`define SNM_CS_SETUP_NS  1000
`define SNM_CS_HOLD_NS   1000
// least times, so round up
`define SNM_CS_SETUP_CYC ((`SNM_CS_SETUP_NS + `SNM_CLK_NS - 1) / `SNM_CLK_NS)
`define SNM_CS_HOLD_CYC  ((`SNM_CS_HOLD_NS + `SNM_CLK_NS - 1) / `SNM_CLK_NS)
// half period of the serial clock in core cycles
`define SNM_HALF_CYC     4
`define SNM_TIMER_W      5
`define SNM_DEV_NUM      2
`define SNM_LANE_NUM     4
`define SNM_OE_ALL_OFF   4'b1111
`define SNM_OE_DUAL_ON   4'b1100
`define SNM_OE_QUAD_ON   4'b0000

`endif

//--- core/snm_pkg.sv
/*
  types of the serial nor flash master link.
  assumes nothing of its surroundings.
*/
package snm_pkg;

  typedef enum logic [1:0] {
    SNM_SINGLE,
    SNM_DUAL,
    SNM_QUAD
  } snm_lane_mode_e;

  typedef enum logic [2:0] {
    SNM_IDLE,
    SNM_SETUP,
    SNM_LOW,
    SNM_HIGH,
    SNM_WAIT,
    SNM_HOLD
  } snm_state_e;

endpackage

//--- core/snm_shift_if.sv
/*
  carrier between the link sequencer and its byte shifter.
  assumes both ends run on the same core clock.
*/
`timescale 1ns/1ns
`default_nettype none

interface snm_shift_if;
  logic                    load;
  logic                    launch;
  logic                    sample;
  logic                    release_lanes;
  snm_pkg::snm_lane_mode_e load_mode;
  logic                    load_read;
  logic [7:0]              load_byte;
  logic                    last_step;
  logic [7:0]              rx_byte;
  logic [3:0]              lane_in;
  logic                    ser_in;
  logic [3:0]              lane_out;
  logic [3:0]              lane_oe_n;
  logic                    ser_out;

  modport ctrl (
    output load, launch, sample, release_lanes, load_mode, load_read, load_byte,
    output lane_in, ser_in,
    input  last_step, rx_byte, lane_out, lane_oe_n, ser_out
  );
  modport shift (
    input  load, launch, sample, release_lanes, load_mode, load_read, load_byte,
    input  lane_in, ser_in,
    output last_step, rx_byte, lane_out, lane_oe_n, ser_out
  );
endinterface

`default_nettype wire

//--- core/snm_shifter.sv
/*
  byte shifter: spreads one byte over one, two or four lanes msb first
  and gathers incoming bits into a byte.
  assumes the sequencer pulses launch at each load and at each falling serial clock edge
  but the first of a frame, and sample at each rising one, with synchronised lane inputs.
*/
`timescale 1ns/1ns
`default_nettype none
`include "snm_consts.svh"

module snm_shifter (
  // clock and reset
  input  wire logic ref_clk_in,
  input  wire logic arst_n_in,
  // sequencer side
  snm_shift_if.shift sh
);

  snm_pkg::snm_lane_mode_e mode;
  snm_pkg::snm_lane_mode_e src_mode;
  logic [7:0]              sr;
  logic [7:0]              src;
  logic [7:0]              rx;
  logic [2:0]              step;
  logic [2:0]              step_max;
  logic [3:0]              lane_out;
  logic [3:0]              lane_oe_n;
  logic                    ser_out;
  logic [7:0]              next_sr;
  logic [7:0]              next_rx;
  logic [3:0]              next_oe_n;

  // a load is also the first launch, so lanes settle before the first fall
  assign src      = sh.load ? sh.load_byte : sr;
  assign src_mode = sh.load ? sh.load_mode : mode;
  assign step_max = (mode == snm_pkg::SNM_QUAD) ? 3'h1 :
                    (mode == snm_pkg::SNM_DUAL) ? 3'h3 : 3'h7;

  always_comb
  begin
    case (src_mode)
      snm_pkg::SNM_DUAL:
      begin
        next_sr   = {src[5:0], 2'b00};
        next_oe_n = sh.load_read ? `SNM_OE_ALL_OFF : `SNM_OE_DUAL_ON;
      end
      snm_pkg::SNM_QUAD:
      begin
        next_sr   = {src[3:0], 4'h0};
        next_oe_n = sh.load_read ? `SNM_OE_ALL_OFF : `SNM_OE_QUAD_ON;
      end
      default:
      begin
        next_sr   = {src[6:0], 1'b0};
        next_oe_n = `SNM_OE_ALL_OFF;
      end
    endcase
  end

  always_comb
  begin
    case (mode)
      snm_pkg::SNM_DUAL: next_rx = {rx[5:0], sh.lane_in[1], sh.lane_in[0]}; // RL5
      snm_pkg::SNM_QUAD: next_rx = {rx[3:0], sh.lane_in[3:0]}; // RL6
      default:           next_rx = {rx[6:0], sh.ser_in}; // RL3
    endcase
  end

  always_ff @(posedge ref_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      mode      <= snm_pkg::SNM_SINGLE;
      sr        <= 8'h00;
      step      <= 3'h0;
      lane_out  <= 4'h0;
      ser_out   <= 1'b1;
    end
    else if (sh.launch)
    begin
      mode <= src_mode;
      sr   <= next_sr; // RL2
      step <= sh.load ? 3'h0 : step + 3'h1;
      case (src_mode)
        snm_pkg::SNM_DUAL: lane_out[1:0] <= src[7:6]; // RL5
        snm_pkg::SNM_QUAD: lane_out      <= src[7:4]; // RL6
        default:           ser_out       <= src[7]; // RL7
      endcase
    end
  end

  always_ff @(posedge ref_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      lane_oe_n <= `SNM_OE_ALL_OFF;
    else if (sh.release_lanes)
      lane_oe_n <= `SNM_OE_ALL_OFF;
    else if (sh.load)
      lane_oe_n <= next_oe_n;
  end

  always_ff @(posedge ref_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      rx <= 8'h00;
    else if (sh.sample)
      rx <= next_rx; // RL3
  end

  assign sh.last_step = (step == step_max);
  assign sh.rx_byte   = rx;
  assign sh.lane_out  = lane_out;
  assign sh.lane_oe_n = lane_oe_n;
  assign sh.ser_out   = ser_out;

endmodule

`default_nettype wire

//--- core/snm_link.sv
/*
  serial nor flash master link: frames a byte stream onto a mode 3 serial
  bus in single, dual or quad lanes, with a plain select per flash.
  assumes a 25 mhz core clock, an asynchronous active-low reset, and that
  the pad ring resolves each lane from its output and active-low enable.
*/
`timescale 1ns/1ns
`default_nettype none
`include "snm_consts.svh"

// How it works
// RL1: serial clock idles high, data launched on falls, sampled on rises (mode 3).
// RL2: outgoing bits change at each falling clock edge but a frame's first, whose bit is set when the byte is taken; most significant bit first.
// RL3: incoming bits sampled at each rising clock edge, first bit lands in bit 7.
// RL4: serial clock output stays high whenever no transfer is running.
// RL5: dual lanes: lane one carries bits 7,5,3,1; lane zero bits 6,4,2,0.
// RL6: quad lanes: lanes three to zero carry bits 7-4, then bits 3-0.
// RL7: single lane uses a dedicated serial output and dedicated serial input.
// RL8: flash select is a plain active-low output, not part of the shifter.
// RL9: about 1 us passes from select low to the first falling clock edge.
// RL10: about 1 us passes from the last rising clock edge to select high.
// RL11: one always-driven select output per attached flash.
// RL12: bytes leave in stream order and received bytes emerge in arrival order.
module snm_link (
  // clock and reset
  input  wire logic       ref_clk_in,
  input  wire logic       arst_n_in,
  // transmit byte stream
  input  wire logic       tx_valid_in,
  output logic            tx_ready_out,
  input  wire logic [7:0] tx_data_in,
  input  wire logic [1:0] tx_mode_in,
  input  wire logic       tx_read_in,
  input  wire logic       tx_last_in,
  input  wire logic       tx_dev_in,
  // receive byte stream
  output logic            rx_valid_out,
  output logic [7:0]      rx_data_out,
  output logic            busy_out,
  // flash pins
  output logic            sck_out,
  output logic [1:0]      flash_sel_n_out,
  output logic            master_serial_out,
  input  wire logic       master_serial_in,
  input  wire logic [3:0] data_lane_in,
  output logic [3:0]      data_lane_out,
  output logic [3:0]      data_lane_oe_n_out
);

  localparam logic [`SNM_TIMER_W-1:0] SETUP_LOAD = `SNM_TIMER_W'(`SNM_CS_SETUP_CYC - 1);
  localparam logic [`SNM_TIMER_W-1:0] HOLD_LOAD  = `SNM_TIMER_W'(`SNM_CS_HOLD_CYC - 1);
  localparam logic [`SNM_TIMER_W-1:0] HALF_LOAD  = `SNM_TIMER_W'(`SNM_HALF_CYC - 1);

  snm_shift_if sh ();

  snm_pkg::snm_state_e    state;
  snm_pkg::snm_state_e    next_state;
  logic [`SNM_TIMER_W-1:0] timer;
  logic [`SNM_TIMER_W-1:0] next_timer;
  logic                   sck;
  logic                   next_sck;
  logic [1:0]             sel_n;
  logic [1:0]             next_sel_n;
  logic [1:0]             sel_hit_n;
  logic                   last_q;
  logic                   rx_valid;
  logic                   next_rx_valid;
  logic                   step_launch;
  logic                   step_sample;
  logic                   release_lanes;
  logic [4:0]             pin_meta;
  logic [4:0]             pin_sync;
  logic                   timer_zero;
  logic                   tx_accept;

  // pins from the flash: two flops before any logic looks at them
  always_ff @(posedge ref_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      pin_meta <= 5'h00;
      pin_sync <= 5'h00;
    end
    else
    begin
      pin_meta <= {master_serial_in, data_lane_in};
      pin_sync <= pin_meta;
    end
  end

  // decoding
  assign timer_zero   = (timer == '0);
  assign tx_ready_out = (state == snm_pkg::SNM_IDLE) || (state == snm_pkg::SNM_WAIT);
  assign tx_accept    = tx_valid_in & tx_ready_out; // RL12

  // one select per flash, picked once at the start of a frame
  genvar gi;
  generate
    for (gi = 0; gi < `SNM_DEV_NUM; gi = gi + 1)
    begin : g_sel
      assign sel_hit_n[gi] = (tx_dev_in != 1'(gi)); // RL11
    end
  endgenerate

  // shifter hook-up
  assign sh.load          = tx_accept;
  assign sh.launch        = tx_accept | step_launch; // RL2
  assign sh.sample        = step_sample; // RL3
  assign sh.release_lanes = release_lanes;
  assign sh.load_mode     = (tx_mode_in == 2'h1) ? snm_pkg::SNM_DUAL :
                            (tx_mode_in == 2'h2) ? snm_pkg::SNM_QUAD :
                                                   snm_pkg::SNM_SINGLE;
  assign sh.load_read     = tx_read_in;
  assign sh.load_byte     = tx_data_in;
  assign sh.lane_in       = pin_sync[3:0];
  assign sh.ser_in        = pin_sync[4];

  snm_shifter u_shifter (
    .ref_clk_in (ref_clk_in),
    .arst_n_in  (arst_n_in),
    .sh         (sh)
  );

  // sequencer
  always_comb
  begin
    next_state    = state;
    next_timer    = timer_zero ? timer : timer - `SNM_TIMER_W'(1);
    next_sck      = sck;
    next_sel_n    = sel_n;
    next_rx_valid = 1'b0;
    step_launch   = 1'b0;
    step_sample   = 1'b0;
    release_lanes = 1'b0;
    case (state)
      snm_pkg::SNM_IDLE:
      begin
        next_sck = 1'b1; // RL4
        if (tx_accept)
        begin
          next_sel_n = sel_hit_n; // RL8
          next_timer = SETUP_LOAD;
          next_state = snm_pkg::SNM_SETUP;
        end
      end
      snm_pkg::SNM_SETUP:
      begin
        if (timer_zero)
        begin
          next_sck   = 1'b0; // RL9
          next_timer = HALF_LOAD;
          next_state = snm_pkg::SNM_LOW;
        end
      end
      snm_pkg::SNM_LOW:
      begin
        if (timer_zero)
        begin
          step_sample = 1'b1; // RL1
          next_sck    = 1'b1;
          next_timer  = HALF_LOAD;
          next_state  = snm_pkg::SNM_HIGH;
        end
      end
      snm_pkg::SNM_HIGH:
      begin
        if (timer_zero)
        begin
          if (!sh.last_step)
          begin
            step_launch = 1'b1; // RL1
            next_sck    = 1'b0;
            next_timer  = HALF_LOAD;
            next_state  = snm_pkg::SNM_LOW;
          end
          else
          begin
            next_rx_valid = 1'b1; // RL12
            if (last_q)
            begin
              release_lanes = 1'b1;
              next_timer    = HOLD_LOAD; // RL10
              next_state    = snm_pkg::SNM_HOLD;
            end
            else
              next_state = snm_pkg::SNM_WAIT;
          end
        end
      end
      snm_pkg::SNM_WAIT:
      begin
        // clock parked high while the stream has no byte ready
        if (tx_accept)
        begin
          next_sck   = 1'b0;
          next_timer = HALF_LOAD;
          next_state = snm_pkg::SNM_LOW;
        end
      end
      snm_pkg::SNM_HOLD:
      begin
        if (timer_zero)
        begin
          next_sel_n = 2'h3; // RL10
          next_state = snm_pkg::SNM_IDLE;
        end
      end
      default:
      begin
        next_sck   = 1'b1;
        next_sel_n = 2'h3;
        next_state = snm_pkg::SNM_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      state    <= snm_pkg::SNM_IDLE;
      timer    <= '0;
      sck      <= 1'b1; // RL4
      sel_n    <= 2'h3; // RL11
      rx_valid <= 1'b0;
    end
    else
    begin
      state    <= next_state;
      timer    <= next_timer;
      sck      <= next_sck;
      sel_n    <= next_sel_n;
      rx_valid <= next_rx_valid;
    end
  end

  always_ff @(posedge ref_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      last_q <= 1'b0;
    else if (tx_accept)
      last_q <= tx_last_in;
  end

  // outputs
  assign sck_out            = sck;
  assign flash_sel_n_out    = sel_n;
  assign master_serial_out  = sh.ser_out; // RL7
  assign data_lane_out      = sh.lane_out;
  assign data_lane_oe_n_out = sh.lane_oe_n;
  assign rx_valid_out       = rx_valid;
  assign rx_data_out        = sh.rx_byte;
  assign busy_out           = (state != snm_pkg::SNM_IDLE);

endmodule

`default_nettype wire

//--- sim/snm_flash_model.sv
/*
  behavioural serial nor flash on the far side of the link.
  assumes mode 3 framing and one flash serving whichever select is low.
*/
`timescale 1ns/1ns
`default_nettype none

module snm_flash_model (
  // pins
  input  wire logic       sck_in,
  input  wire logic       sel_n_in,
  input  wire logic [3:0] drv_in,
  input  wire logic [3:0] oe_n_in,
  input  wire logic       si_in,
  output logic            so_out,
  output logic [3:0]      lane_out,
  // test control
  input  wire logic [1:0] mode_in,
  input  wire logic [7:0] rd_in,
  output logic [7:0]      wr_out
);
  logic [3:0] drv = 4'h0;
  int         k   = 0;

  initial so_out = 1'b0;
  initial wr_out = 8'h00;
  // no keeper: a released lane shows only what the flash drives
  assign lane_out = (oe_n_in & drv) | (~oe_n_in & drv_in);
  always @(negedge sel_n_in) k = 0;
  // deselected: inverse of last value, never a stale copy
  always @(posedge sel_n_in)
  begin
    drv = ~drv;
    so_out = ~so_out;
  end
  always @(negedge sck_in)
    if (!sel_n_in)
    begin
      case (mode_in)
        2'h1: drv[1:0] = rd_in[7 - 2 * k -: 2];
        2'h2: drv = rd_in[7 - 4 * k -: 4];
        default: so_out = rd_in[7 - k];
      endcase
      // mode code 3 runs as single lane, so it wraps after eight bits too
      k = (k + 1) % ((mode_in == 2'h1) ? 4 : (mode_in == 2'h2) ? 2 : 8);
    end
  always @(posedge sck_in)
    if (!sel_n_in)
      case (mode_in)
        2'h1: wr_out = {wr_out[5:0], lane_out[1:0]};
        2'h2: wr_out = {wr_out[3:0], lane_out};
        default: wr_out = {wr_out[6:0], si_in};
      endcase
endmodule

`default_nettype wire

//--- sim/snm_link_monitor.sv
/*
  port checker of the serial nor flash master link.
  assumes the 25 mhz core clock and async active-low reset.
*/
`timescale 1ns/1ns
`default_nettype none

module snm_link_monitor (
  // clock and reset
  input wire logic       ref_clk_in,
  input wire logic       arst_n_in,
  // observed ports
  input wire logic       busy_out,
  input wire logic       rx_valid_out,
  input wire logic       sck_out,
  input wire logic [1:0] flash_sel_n_out,
  input wire logic [3:0] data_lane_out,
  input wire logic [3:0] data_lane_oe_n_out
);
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!arst_n_in);
  logic [4:0] set_cnt;
  logic [4:0] hold_cnt;
  logic       sck_was;
  wire        desel = &flash_sel_n_out;

  // saturating counts: since select fell, since the last clock rise
  always_ff @(posedge ref_clk_in or negedge arst_n_in)
    if (!arst_n_in)
    begin
      set_cnt <= 5'h00;
      hold_cnt <= 5'h00;
      sck_was <= 1'b1;
    end
    else
    begin
      sck_was <= sck_out;
      set_cnt <= desel ? 5'h00 : set_cnt + {4'h0, set_cnt != 5'h1f};
      hold_cnt <= (sck_out & ~sck_was) ? 5'h00 : hold_cnt + {4'h0, hold_cnt != 5'h1f};
    end

  sequence low_phase;
    !sck_out [*4];
  endsequence
  sequence one_pulse;
    busy_out ##1 !rx_valid_out;
  endsequence

  idle_clock_a: assert property (!busy_out |-> sck_out)
    else $error("clock low while idle");
  framed_clock_a: assert property (!sck_out |-> !desel)
    else $error("clock low while deselected");
  half_period_a: assert property ($fell(sck_out) |-> low_phase ##1 sck_out)
    else $error("low phase not four cycles");
  setup_wait_a: assert property ($fell(sck_out) |-> set_cnt >= 5'h18)
    else $error("select setup too short");
  hold_wait_a: assert property ($rose(desel) |-> hold_cnt >= 5'h18)
    else $error("select hold too short");
  one_select_a: assert property (flash_sel_n_out != 2'h0)
    else $error("two selects low");
  released_lanes_a: assert property (desel |-> data_lane_oe_n_out == 4'hf)
    else $error("lanes driven while deselected");
  lane_launch_a: assert property (sck_out && $stable(sck_out) && !desel
    && $stable(flash_sel_n_out) && data_lane_oe_n_out != 4'hf
    && $stable(data_lane_oe_n_out) |-> $stable(data_lane_out))
    else $error("lane changed off a falling edge");
  rx_pulse_a: assert property (rx_valid_out |-> one_pulse)
    else $error("byte pulse not single");
endmodule

bind snm_link snm_link_monitor mon (
  .ref_clk_in         (ref_clk_in),
  .arst_n_in          (arst_n_in),
  .busy_out           (busy_out),
  .rx_valid_out       (rx_valid_out),
  .sck_out            (sck_out),
  .flash_sel_n_out    (flash_sel_n_out),
  .data_lane_out      (data_lane_out),
  .data_lane_oe_n_out (data_lane_oe_n_out)
);

`default_nettype wire

//--- sim/tb.sv
/*
  self-checking bench of the link against a behavioural flash.
  assumes the hand-over timing: bytes taken when ready, one pulse each.
*/
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, a) begin checks++; if ((a) !== (e)) begin bad_count++; \
  $display("[FAIL] %s exp %h got %h", n, e, a); end end

module tb;
  logic       ref_clk, arst_n, tx_valid, tx_read, tx_last, tx_dev;
  logic       tx_ready, rx_valid, busy, sck, mso, msi;
  logic [1:0] tx_mode, sel_n, m_mode;
  logic [3:0] lane_in, lane_out, oe_n;
  logic [7:0] tx_data, rx_data, m_rd, m_wr;
  int         bad_count = 0;
  int         checks    = 0;

  snm_link DUT (
    .ref_clk_in(ref_clk), .arst_n_in(arst_n), .tx_valid_in(tx_valid),
    .tx_ready_out(tx_ready), .tx_data_in(tx_data), .tx_mode_in(tx_mode),
    .tx_read_in(tx_read), .tx_last_in(tx_last), .tx_dev_in(tx_dev),
    .rx_valid_out(rx_valid), .rx_data_out(rx_data), .busy_out(busy),
    .sck_out(sck), .flash_sel_n_out(sel_n), .master_serial_out(mso),
    .master_serial_in(msi), .data_lane_in(lane_in), .data_lane_out(lane_out),
    .data_lane_oe_n_out(oe_n)
  );
  snm_flash_model flash (
    .sck_in(sck), .sel_n_in(&sel_n), .drv_in(lane_out), .oe_n_in(oe_n),
    .si_in(mso), .so_out(msi), .lane_out(lane_in), .mode_in(m_mode),
    .rd_in(m_rd), .wr_out(m_wr)
  );

  task automatic close_out;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // hold the byte until taken, then wait bounded for its pulse
  task automatic xfer(input logic [7:0] d, input logic [1:0] m, input logic r, l, v);
    logic ok;
    int   n;
    m_mode = m;
    @(posedge ref_clk);
    #1;
    {tx_valid, tx_data, tx_mode, tx_read, tx_last, tx_dev} = {1'b1, d, m, r, l, v};
    ok = 1'b0;
    while (!ok)
    begin
      @(negedge ref_clk);
      ok = (tx_ready === 1'b1);
      @(posedge ref_clk);
    end
    #1;
    tx_valid = 1'b0;
    `CHK("ready", 1'b0, tx_ready)
    n = 0;
    while (rx_valid !== 1'b1 && n < 300)
    begin
      @(negedge ref_clk);
      n++;
    end
    `CHK("rx pulse", 1'b1, rx_valid)
  endtask

  task automatic check_reset;
    `CHK("sck", 1'b1, sck)
    `CHK("sel", 2'h3, sel_n)
    `CHK("oe", 4'hf, oe_n)
    `CHK("busy", 1'b0, busy)
  endtask

  task automatic single_frame;
    m_rd = 8'h3c;
    xfer(8'ha5, 2'h0, 1'b0, 1'b0, 1'b0);
    `CHK("sel", 2'h2, sel_n)
    `CHK("wr", 8'ha5, m_wr)
    `CHK("rx", 8'h3c, rx_data)
    `CHK("oe", 4'hf, oe_n)
    m_rd = 8'h81;
    xfer(8'h5a, 2'h0, 1'b0, 1'b1, 1'b0);
    `CHK("wr2", 8'h5a, m_wr)
    `CHK("rx2", 8'h81, rx_data)
  endtask

  task automatic dual_frame;
    xfer(8'h96, 2'h1, 1'b0, 1'b0, 1'b1);
    `CHK("sel", 2'h1, sel_n)
    `CHK("oe", 4'hc, oe_n)
    `CHK("wr", 8'h96, m_wr)
    m_rd = 8'h69;
    xfer(8'h00, 2'h1, 1'b1, 1'b1, 1'b1);
    `CHK("rx", 8'h69, rx_data)
  endtask

  task automatic quad_frame;
    xfer(8'he1, 2'h2, 1'b0, 1'b0, 1'b0);
    `CHK("oe", 4'h0, oe_n)
    `CHK("wr", 8'he1, m_wr)
    m_rd = 8'h1e;
    xfer(8'h00, 2'h2, 1'b1, 1'b1, 1'b0);
    `CHK("rx", 8'h1e, rx_data)
  endtask

  // mode code 3 runs as single lane; then the hold before select rises
  task automatic odd_mode_frame;
    m_rd = 8'hc3;
    xfer(8'h3c, 2'h3, 1'b1, 1'b1, 1'b1);
    `CHK("oe", 4'hf, oe_n)
    `CHK("wr", 8'h3c, m_wr)
    `CHK("rx", 8'hc3, rx_data)
    // 1 us at 40 ns is 25 cycles after the byte pulse
    repeat (24) @(posedge ref_clk);
    #1;
    `CHK("sel", 2'h1, sel_n)
    @(posedge ref_clk);
    #1;
    `CHK("sel", 2'h3, sel_n)
    `CHK("busy", 1'b0, busy)
    `CHK("ready", 1'b1, tx_ready)
  endtask

  // reset dropped in mid-frame puts every pin back at once
  task automatic reset_mid_frame;
    @(posedge ref_clk);
    #1;
    tx_data  = 8'h55;
    tx_mode  = 2'h2;
    tx_read  = 1'b0;
    tx_valid = 1'b1;
    @(posedge ref_clk);
    #1;
    tx_valid = 1'b0;
    repeat (26) @(posedge ref_clk);
    #1;
    `CHK("sck", 1'b0, sck)
    `CHK("oe", 4'h0, oe_n)
    arst_n = 1'b0;
    #1;
    check_reset;
    @(posedge ref_clk);
    #1;
    arst_n = 1'b1;
    @(posedge ref_clk);
    #1;
    check_reset;
  endtask

  initial
  begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  initial
  begin
    {arst_n, tx_valid, tx_data, tx_mode, tx_read, tx_last, tx_dev} = 15'h0000;
    {m_mode, m_rd} = 10'h000;
    repeat (16) @(posedge ref_clk);
    #1;
    arst_n = 1'b1;
    check_reset;
    single_frame;
    dual_frame;
    quad_frame;
    odd_mode_frame;
    reset_mid_frame;
    repeat (40) @(posedge ref_clk);
    close_out;
  end
  // frames take well under a thousand cycles
  initial
  begin
    #100000;
    bad_count++;
    close_out;
  end
endmodule

`default_nettype wire
